// >>> logic/pdmc_defs.svh
`ifndef PDMC_DEFS_SVH
`define PDMC_DEFS_SVH
// Register indices on the plain register port.
`define PDMC_ADDR_PRIMARY   2'h0
`define PDMC_ADDR_SECONDARY 2'h1
`define PDMC_ADDR_MODE      2'h2
// Primary control register fields.
`define PDMC_P_STANDBY_SELECT   7
`define PDMC_P_WWS_HI 6
`define PDMC_P_WWS_LO 4
`define PDMC_P_LSS    3
`define PDMC_P_FIXED  3'h7
// Secondary control register fields.
`define PDMC_S_NSR    4
`define PDMC_S_DTS    3
`define PDMC_S_MSS    2
`define PDMC_S_DIV_HI 1
`define PDMC_S_DIV_LO 0
`define PDMC_S_FIXED  3'h7
// Settling wait lengths in states.
`define PDMC_WAIT_0   18'h02000
`define PDMC_WAIT_1   18'h04000
`define PDMC_WAIT_2   18'h08000
`define PDMC_WAIT_3   18'h10000
`define PDMC_WAIT_4   18'h20000
// Noise sampler divide ratios, as terminal counts.
`define PDMC_NS_SLOW  4'hF
`define PDMC_NS_FAST  4'h3
`endif

// >>> logic/pdmc_pkg.sv
package pdmc_pkg;
   // Operating modes, one-hot.
   typedef enum logic [7:0] {
      PDMC_HIGH    = 8'h01,
      PDMC_MEDIUM  = 8'h02,
      PDMC_SLEEP   = 8'h04,
      PDMC_STANDBY = 8'h08,
      PDMC_WATCH   = 8'h10,
      PDMC_SUBACT  = 8'h20,
      PDMC_SUBSLP  = 8'h40,
      PDMC_SETTLE  = 8'h80
   } pdmc_mode_t;

   // Wake sources grouped.
   typedef struct packed {
      logic [4:0] irq;
      logic [7:0] wkp;
      logic       tmr_a;
      logic       tmr_b;
      logic       tmr_c;
      logic       tmr_f;
      logic       tmr_g;
      logic [2:0] sci;
      logic       adc;
   } pdmc_wake_t;

   // Whole module state.
   typedef struct packed {
      pdmc_mode_t mode;
      logic       standby_select;
      logic [2:0] wws;
      logic       lss;
      logic       nsr;
      logic       dts;
      logic       mss;
      logic [1:0] div;
      logic [17:0] wait_cnt;
      logic       resume_med;
      logic [3:0] ns_cnt;
      logic       ns_tick;
      logic [7:0] rdata;
      logic       exc_start;
      logic       osc_run;
      logic       cpu_halt;
      logic       pwm_halt;
      logic       periph_halt;
      logic       port_hiz;
   } pdmc_state_t;
endpackage

// >>> logic/pdmc_ctrl.sv
// What this block does
// - Standby select clear: sleep from active, subsleep from subactive.
// - Standby select set: active goes standby or watch, subactive to watch.
// - Active, standby set, low speed and watch clear: enter standby, halt all.
// - Wake wait field picks 8192 to 131072 states; resets to zero.
// - Low speed select picks system clock or subclock after watch.
// - Primary bits 2..0 and secondary bits 7..5 read one, ignore writes.
// - Noise rate select samples watch clock at osc/16 or osc/4.
// - Direct transfer clear: normal low-power transitions only.
// - Direct transfer from high speed to medium speed or subactive.
// - Direct transfer from medium speed to high speed or subactive.
// - Direct transfer from subactive to active, speed by medium select.
// - Medium select picks active speed after standby, watch or sleep.
// - Subactive divider picks /8, /4, /2; frozen while subactive.
// - Active with standby and low speed clear enters sleep; PWM halts.
// - Sleep ends on any listed peripheral interrupt or reset.
// - Sleep wake starts exception handling in the chosen active speed.
// - Masked or disabled interrupts never wake sleep or standby.
// - Reset pin low resets and ends sleep.
// - Standby ends only on irq 0, 1, wakeup pins, or reset.
// - Standby wake restarts oscillator, waits, then resumes active.
// - Standby and watch select set from active or subactive: watch.
// - Subactive with standby clear, low speed and watch set: subsleep.
`timescale 1ns/1ns
`default_nettype none
`include "pdmc_defs.svh"
module pdmc_ctrl
   import pdmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       sleep_exec,
   input  wire logic       watch_sel,
   input  wire logic       int_mask,
   input  wire pdmc_wake_t wake_req,
   input  wire pdmc_wake_t wake_en,
   output pdmc_mode_t      mode,
   output logic [1:0]      sub_div,
   output logic            noise_tick,
   output logic            exc_start,
   output logic            osc_run,
   output logic            cpu_halt,
   output logic            pwm_halt,
   output logic            periph_halt,
   output logic            port_hiz
);

   pdmc_state_t st_ff;
   pdmc_state_t nxt_st;
   pdmc_wake_t  act;
   logic        any_sleep_wake;
   logic        any_stby_wake;
   logic        any_watch_wake;
   logic [17:0] wait_len;
   logic        dt_hi_med;
   logic        dt_med_hi;
   logic        dt_to_sub;
   logic        dt_sub_act;

   // Interrupts that are both requested and enabled.
   // mask gating
   assign act = (int_mask) ? '0 : (wake_req & wake_en);

   // Sleep wakes on any source.
   // sleep sources
   assign any_sleep_wake = |act;
   // Standby wakes only on the two lowest irq lines or wakeup pins.
   // standby sources
   assign any_stby_wake = act.irq[0] | act.irq[1] | (|act.wkp);
   // Watch wakes on timer A, irq 0 or wakeup pins.
   assign any_watch_wake = act.tmr_a | act.irq[0] | (|act.wkp);

   // Settling length decode.
   // wait decode
   always_comb begin
      case (st_ff.wws)
         3'h0:    wait_len = `PDMC_WAIT_0;
         3'h1:    wait_len = `PDMC_WAIT_1;
         3'h2:    wait_len = `PDMC_WAIT_2;
         3'h3:    wait_len = `PDMC_WAIT_3;
         default: wait_len = `PDMC_WAIT_4;
      endcase
   end

   // Direct transfer conditions.
   // high to medium
   assign dt_hi_med = st_ff.dts & ~st_ff.standby_select & st_ff.mss & ~st_ff.lss;
   assign dt_med_hi = st_ff.dts & ~st_ff.standby_select & ~st_ff.mss & ~st_ff.lss;
   assign dt_to_sub = st_ff.dts & st_ff.standby_select & watch_sel & st_ff.lss;
   assign dt_sub_act = st_ff.dts & st_ff.standby_select & watch_sel & ~st_ff.lss;

   // Next state of the whole controller.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.exc_start = 1'b0;
      nxt_st.rdata = 8'h00;
      nxt_st.ns_tick = 1'b0;

      // Register writes; fixed bits are not stored.
      // fixed bits
      if (reg_wr && reg_addr == `PDMC_ADDR_PRIMARY) begin
         nxt_st.standby_select = reg_wdata[`PDMC_P_STANDBY_SELECT];
         nxt_st.wws  = reg_wdata[`PDMC_P_WWS_HI:`PDMC_P_WWS_LO];
         nxt_st.lss  = reg_wdata[`PDMC_P_LSS];
      end
      if (reg_wr && reg_addr == `PDMC_ADDR_SECONDARY) begin
         nxt_st.nsr = reg_wdata[`PDMC_S_NSR];
         nxt_st.dts = reg_wdata[`PDMC_S_DTS];
         nxt_st.mss = reg_wdata[`PDMC_S_MSS];
         if (st_ff.mode != PDMC_SUBACT) begin
            nxt_st.div = reg_wdata[`PDMC_S_DIV_HI:`PDMC_S_DIV_LO];
         end
      end

      // Read data, valid the cycle after the strobe.
      if (reg_rd) begin
         case (reg_addr)
            `PDMC_ADDR_PRIMARY:
               nxt_st.rdata = {st_ff.standby_select, st_ff.wws, st_ff.lss,
                               `PDMC_P_FIXED};
            `PDMC_ADDR_SECONDARY:
               nxt_st.rdata = {`PDMC_S_FIXED, st_ff.nsr, st_ff.dts,
                               st_ff.mss, st_ff.div};
            `PDMC_ADDR_MODE:
               nxt_st.rdata = st_ff.mode;
            default:
               nxt_st.rdata = 8'h00;
         endcase
      end

      // Noise sampling enable, oscillator divided by 16 or 4.
      // sampling rate
      if (st_ff.ns_cnt >= (st_ff.nsr ? `PDMC_NS_FAST : `PDMC_NS_SLOW)) begin
         nxt_st.ns_cnt  = 4'h0;
         nxt_st.ns_tick = 1'b1;
      end else begin
         nxt_st.ns_cnt = st_ff.ns_cnt + 4'h1;
      end

      // Mode sequencer.
      case (st_ff.mode)
         PDMC_HIGH, PDMC_MEDIUM: begin
            if (sleep_exec) begin
               if (st_ff.mode == PDMC_HIGH && dt_hi_med) begin
                  nxt_st.mode = PDMC_MEDIUM;
               end else if (st_ff.mode == PDMC_MEDIUM && dt_med_hi) begin
                  nxt_st.mode = PDMC_HIGH;
               end else if (dt_to_sub) begin
                  nxt_st.mode = PDMC_SUBACT;
               end else if (st_ff.standby_select && watch_sel) begin
                  nxt_st.mode = PDMC_WATCH;
               end else if (st_ff.standby_select && !st_ff.lss) begin
                  nxt_st.mode = PDMC_STANDBY;
               end else if (!st_ff.standby_select && !st_ff.lss) begin
                  nxt_st.mode = PDMC_SLEEP;
               end
            end
         end
         PDMC_SLEEP: begin
            if (any_sleep_wake) begin
               nxt_st.mode = st_ff.mss ? PDMC_MEDIUM : PDMC_HIGH;
               nxt_st.exc_start = 1'b1;
            end
         end
         PDMC_STANDBY: begin
            if (any_stby_wake) begin
               nxt_st.mode = PDMC_SETTLE;
               nxt_st.wait_cnt = wait_len;
               nxt_st.resume_med = st_ff.mss;
            end
         end
         PDMC_WATCH: begin
            if (any_watch_wake) begin
               if (st_ff.lss) begin
                  nxt_st.mode = PDMC_SUBACT;
                  nxt_st.exc_start = 1'b1;
               end else begin
                  nxt_st.mode = PDMC_SETTLE;
                  nxt_st.wait_cnt = wait_len;
                  nxt_st.resume_med = st_ff.mss;
               end
            end
         end
         PDMC_SETTLE: begin
            if (st_ff.wait_cnt <= 18'h00001) begin
               nxt_st.mode = st_ff.resume_med ? PDMC_MEDIUM : PDMC_HIGH;
               nxt_st.exc_start = 1'b1;
               nxt_st.wait_cnt = 18'h00000;
            end else begin
               nxt_st.wait_cnt = st_ff.wait_cnt - 18'h00001;
            end
         end
         PDMC_SUBACT: begin
            if (sleep_exec) begin
               if (dt_sub_act) begin
                  nxt_st.mode = st_ff.mss ? PDMC_MEDIUM : PDMC_HIGH;
               end else if (st_ff.standby_select && watch_sel) begin
                  nxt_st.mode = PDMC_WATCH;
               end else if (!st_ff.standby_select && st_ff.lss && watch_sel) begin
                  nxt_st.mode = PDMC_SUBSLP;
               end
            end
         end
         PDMC_SUBSLP: begin
            if (act.tmr_a | act.tmr_c | act.tmr_g | (|act.irq) |
                (|act.wkp)) begin
               nxt_st.mode = PDMC_SUBACT;
               nxt_st.exc_start = 1'b1;
            end
         end
         default: nxt_st.mode = PDMC_HIGH;
      endcase

      // Power-down effects of the coming mode.
      nxt_st.cpu_halt = (nxt_st.mode != PDMC_HIGH) &&
                        (nxt_st.mode != PDMC_MEDIUM) &&
                        (nxt_st.mode != PDMC_SUBACT);
      nxt_st.pwm_halt = (nxt_st.mode != PDMC_HIGH) &&
                        (nxt_st.mode != PDMC_MEDIUM);
      nxt_st.periph_halt = (nxt_st.mode == PDMC_STANDBY) ||
                           (nxt_st.mode == PDMC_SETTLE) ||
                           (nxt_st.mode == PDMC_WATCH);
      nxt_st.osc_run = (nxt_st.mode == PDMC_HIGH) ||
                       (nxt_st.mode == PDMC_MEDIUM) ||
                       (nxt_st.mode == PDMC_SLEEP) ||
                       (nxt_st.mode == PDMC_SETTLE);
      nxt_st.port_hiz = (nxt_st.mode == PDMC_STANDBY) ||
                        (nxt_st.mode == PDMC_SETTLE);
   end

   // State register; reset ends every low-power mode.
   // reset exit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '{mode: PDMC_HIGH, osc_run: 1'b1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata   = st_ff.rdata;
   assign mode        = st_ff.mode;
   assign sub_div     = st_ff.div;
   assign noise_tick  = st_ff.ns_tick;
   assign exc_start   = st_ff.exc_start;
   assign osc_run     = st_ff.osc_run;
   assign cpu_halt    = st_ff.cpu_halt;
   assign pwm_halt    = st_ff.pwm_halt;
   assign periph_halt = st_ff.periph_halt;
   assign port_hiz    = st_ff.port_hiz;

   // Sequences for the assertions below.
   sequence sleep_enter_s;
      sleep_exec && st_ff.mode == PDMC_HIGH && !st_ff.standby_select && !st_ff.lss
      && !st_ff.dts;
   endsequence

   sequence stby_wake_s;
      st_ff.mode == PDMC_STANDBY && any_stby_wake;
   endsequence

   sequence stby_wait_s;
      (st_ff.mode == PDMC_SETTLE) [*8];
   endsequence

   sequence watch_enter_s;
      sleep_exec && st_ff.mode == PDMC_SUBACT && st_ff.standby_select && watch_sel
      && !st_ff.dts;
   endsequence

   // Standby with no unmasked, enabled request on its own wake lines.
   sequence stby_quiet_s;
      st_ff.mode == PDMC_STANDBY && (int_mask ||
      ((wake_req.irq[1:0] & wake_en.irq[1:0]) == 2'h0 &&
      (wake_req.wkp & wake_en.wkp) == 8'h00));
   endsequence

   // Last counted state of the oscillator settling wait.
   sequence settle_end_s;
      st_ff.mode == PDMC_SETTLE && st_ff.wait_cnt == 18'h00001;
   endsequence

   // Fast sampling leaves three quiet cycles between pulses.
   sequence fast_gap_s;
      !noise_tick [*3];
   endsequence

   sleep_entry_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      sleep_enter_s |=> mode == PDMC_SLEEP && cpu_halt && pwm_halt
      && !periph_halt)
      else $error("sleep not entered");

   standby_entry_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      sleep_exec && st_ff.mode == PDMC_HIGH && st_ff.standby_select && !st_ff.lss
      && !watch_sel && !st_ff.dts |=> mode == PDMC_STANDBY && port_hiz
      && !osc_run && cpu_halt && periph_halt)
      else $error("standby not entered");

   standby_settle_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      stby_wake_s ##1 stby_wait_s |-> !exc_start && osc_run)
      else $error("standby wait cut short");

   wait_length_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      stby_wake_s |=> st_ff.wait_cnt == $past(wait_len))
      else $error("wrong settling length");

   mask_block_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      int_mask && st_ff.mode == PDMC_SLEEP |=> mode == PDMC_SLEEP)
      else $error("masked interrupt woke sleep");

   sleep_resume_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_ff.mode == PDMC_SLEEP && any_sleep_wake |=> exc_start &&
      mode == ($past(st_ff.mss) ? PDMC_MEDIUM : PDMC_HIGH))
      else $error("sleep wake wrong");

   watch_entry_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      watch_enter_s |=> mode == PDMC_WATCH)
      else $error("watch not entered");

   div_freeze_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_ff.mode == PDMC_SUBACT |=> $stable(sub_div))
      else $error("divider changed in subactive");

   fixed_bits_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && reg_addr == `PDMC_ADDR_PRIMARY |=>
      reg_rdata[2:0] == `PDMC_P_FIXED)
      else $error("fixed bits not one");

   fixed_upper_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && reg_addr == `PDMC_ADDR_SECONDARY |=>
      reg_rdata[7:5] == `PDMC_S_FIXED)
      else $error("upper fixed bits not one");

   stby_hold_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      stby_quiet_s |=> mode == PDMC_STANDBY && port_hiz)
      else $error("standby left without a wake source");

   settle_exit_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      settle_end_s |=> exc_start && !port_hiz && osc_run
      && (mode == PDMC_HIGH || mode == PDMC_MEDIUM))
      else $error("settling wait did not resume");

   fast_rate_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      noise_tick && st_ff.nsr |=> fast_gap_s)
      else $error("noise pulses too close");

endmodule
`default_nettype wire

// >>> bench/pdmc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the CPU core and the interrupt sources around the block.
module pdmc_cpu_model
   import pdmc_pkg::*;
(
   input  wire logic  clk,
   output logic       sleep_exec,
   output pdmc_wake_t wake_req
);
   // Quiet lines from time zero.
   initial begin
      sleep_exec = 1'b0;
      wake_req   = '0;
   end

   // One-cycle sleep instruction pulse, launched just after an edge.
   task automatic sleep_cmd();
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
   endtask

   // Interrupt request levels stay up until the next call.
   task automatic raise(input pdmc_wake_t w);
      @(posedge clk);
      wake_req <= w;
   endtask
endmodule
`default_nettype wire

// >>> bench/power_down_mode_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module power_down_mode_control_tb import pdmc_pkg::*;;
   logic       clk, reset_n, reg_wr, reg_rd, sleep_exec, watch_sel;
   logic       int_mask, noise_tick, exc_start, osc_run, cpu_halt;
   logic       pwm_halt, periph_halt, port_hiz;
   logic [1:0] reg_addr, sub_div;
   logic [7:0] reg_wdata, reg_rdata;
   pdmc_wake_t wake_req, wake_en;
   pdmc_mode_t mode;
   int         fails, check_count, exc_n, n, i;

   pdmc_ctrl dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
      .watch_sel(watch_sel), .int_mask(int_mask), .wake_req(wake_req),
      .wake_en(wake_en), .mode(mode), .sub_div(sub_div),
      .noise_tick(noise_tick), .exc_start(exc_start), .osc_run(osc_run),
      .cpu_halt(cpu_halt), .pwm_halt(pwm_halt),
      .periph_halt(periph_halt), .port_hiz(port_hiz));
   pdmc_cpu_model cpu (.clk(clk), .sleep_exec(sleep_exec),
      .wake_req(wake_req));

   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Counts exception starts mid-cycle, where the pulse has settled.
   always @(negedge clk) begin
      if (exc_start === 1'b1) begin
         exc_n++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   task automatic go(input logic [7:0] e);
      cpu.sleep_cmd();
      tick(3);
      chk(mode, e);
   endtask

   task automatic wk(input logic [21:0] w, input logic [7:0] e);
      cpu.raise(pdmc_wake_t'(w));
      tick(3);
      chk(mode, e);
      cpu.raise('0);
   endtask

   // Counts the cycles spent waiting for the oscillator after a wake.
   task automatic settle(input int e);
      cpu.raise(pdmc_wake_t'(22'h40000));
      tick(1);
      n = 0;
      while (mode === PDMC_SETTLE) begin
         tick(1);
         n++;
      end
      chk(n, e);
      cpu.raise('0);
   endtask

   // Measures the spacing of noise sampler pulses after two resyncs.
   task automatic per(input int e);
      repeat (2) begin
         tick(1);
         while (noise_tick !== 1'b1) tick(1);
      end
      n = 0;
      do begin
         tick(1);
         n++;
      end while (noise_tick !== 1'b1);
      chk(n, e);
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog sized well above the two settling waits.
   initial begin
      repeat (70000) @(posedge clk);
      fails++;
      stop_test();
   end

   // Main sequence of tests.
   initial begin
      reset_n   = 1'b0;
      reg_addr  = 2'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      watch_sel = 1'b0;
      int_mask  = 1'b0;
      wake_en   = '1;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(2'h0, 8'h07);
      rd(2'h1, 8'hE0);
      rd(2'h3, 8'h00);
      rd(2'h2, 8'h01);
      wr(2'h0, 8'h50);
      rd(2'h0, 8'h57);
      wr(2'h1, 8'h02);
      rd(2'h1, 8'hE2);
      chk(sub_div, 2'h2);
      wr(2'h1, 8'h00);
      wr(2'h0, 8'h00);
      $display("Test registers done");
      int_mask <= 1'b1;
      go(8'h04);
      chk({cpu_halt, pwm_halt, periph_halt}, 3'h6);
      wk(22'h100, 8'h04);
      int_mask <= 1'b0;
      wake_en  <= '0;
      wk(22'h100, 8'h04);
      wake_en <= '1;
      n = exc_n;
      for (i = 0; i < 22; i++) begin
         wk(22'h1 << i, 8'h01);
         go(8'h04);
      end
      chk(exc_n - n, 22);
      wr(2'h1, 8'h04);
      wk(22'h1, 8'h02);
      go(8'h04);
      reset_n <= 1'b0;
      #1;
      chk(mode, 8'h01);
      @(posedge clk);
      reset_n <= 1'b1;
      $display("Test sleep done");
      wr(2'h0, 8'h80);
      go(8'h08);
      chk({osc_run, port_hiz, periph_halt}, 3'h3);
      wk(22'h100000, 8'h08);
      settle(8192);
      chk(mode, 8'h01);
      wr(2'h0, 8'h90);
      wr(2'h1, 8'h04);
      go(8'h08);
      settle(16384);
      chk(mode, 8'h02);
      $display("Test standby done");
      watch_sel <= 1'b1;
      wr(2'h0, 8'h88);
      go(8'h10);
      wk(22'h20000, 8'h20);
      go(8'h10);
      wk(22'h100, 8'h20);
      wr(2'h1, 8'h03);
      rd(2'h1, 8'hE0);
      wr(2'h0, 8'h08);
      go(8'h40);
      wk(22'h200, 8'h20);
      wr(2'h1, 8'h08);
      wr(2'h0, 8'h80);
      n = exc_n;
      go(8'h01);
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h0C);
      go(8'h02);
      wr(2'h1, 8'h08);
      go(8'h01);
      chk(exc_n, n);
      wr(2'h0, 8'h88);
      go(8'h20);
      $display("Test watch done");
      per(16);
      wr(2'h1, 8'h18);
      per(4);
      $display("Test noise done");
      stop_test();
   end
endmodule
`default_nettype wire
